/* verilog/sbm_pkg.sv */
// Operation
// - Master is built to exactly one profile: minimum, full or reduced.
// - Full profile supports data exchange, parameter handling and all other calls.
// - Reduced profile supports data exchange plus a minimal parameter subset.
// - Optional calls may be omitted; implemented calls behave exactly as defined.
// - Start-up, running and shutdown phases each have defined behaviour.
// - Uniform error scheme for all profiles, at least a configuration-match flag.
// - Configuration-match flag may be merged with other status into one output.
// - Error flag is readable on every controller interface.
// - Cycle assumes request 14, pause 3, response 7, pause 2 bit times.
// - Up to nineteen activated slaves, the cycle completes within 3 ms.
// - Twenty to thirty-one slaves: cycle is (1 + slaves) times 156 us.
`default_nettype none
package sbm_pkg;
  // Profiles
  typedef enum logic [1:0] {
    minimum_profile = 2'h0,
    full_profile    = 2'h1,
    reduced_profile = 2'h2
  } sbm_profile_type;

  // Call codes at the controller interface
  localparam logic [4:0] CALL_READ_INPUT     = 5'h01;
  localparam logic [4:0] CALL_WRITE_OUTPUT   = 5'h02;
  localparam logic [4:0] CALL_SET_PERM_PARAM = 5'h03;
  localparam logic [4:0] CALL_GET_PERM_PARAM = 5'h04;
  localparam logic [4:0] CALL_WRITE_PARAM    = 5'h05;
  localparam logic [4:0] CALL_READ_PARAM     = 5'h06;
  localparam logic [4:0] CALL_STORE_PARAMS   = 5'h07;
  localparam logic [4:0] CALL_SET_PERM_CFG   = 5'h08;
  localparam logic [4:0] CALL_GET_PERM_CFG   = 5'h09;
  localparam logic [4:0] CALL_STORE_CFG      = 5'h0A;
  localparam logic [4:0] CALL_READ_ACT_CFG   = 5'h0B;
  localparam logic [4:0] CALL_SET_PROJECTED  = 5'h0C;
  localparam logic [4:0] CALL_GET_PROJECTED  = 5'h0D;
  localparam logic [4:0] CALL_GET_ACTIVATED  = 5'h0E;
  localparam logic [4:0] CALL_GET_DETECTED   = 5'h0F;
  localparam logic [4:0] CALL_GET_FLAGS      = 5'h10;
  localparam logic [4:0] CALL_GET_CFG_OK     = 5'h11;
  localparam logic [4:0] CALL_SET_OP_MODE    = 5'h12;

  // Status codes
  localparam logic [1:0] STATUS_OK          = 2'h0;
  localparam logic [1:0] STATUS_UNSUPPORTED = 2'h1;
  localparam logic [1:0] STATUS_BAD_ADDR    = 2'h2;

  // Flag word bit positions
  localparam int FLAG_CFG_OK      = 0;
  localparam int FLAG_CFG_ACTIVE  = 1;
  localparam int FLAG_NORMAL_OP   = 2;
  localparam int FLAG_OFFLINE     = 3;

  // Reset values
  localparam logic [3:0]  PARAM_RESET = 4'hF;
  localparam logic [7:0]  CFG_RESET   = 8'hFF;

  // Bus timing; the bit time follows from the per-slave slot
  localparam int REQUEST_BITS     = 14;
  localparam int MASTER_PAUSE_BITS = 3;
  localparam int RESPONSE_BITS    = 7;
  localparam int SLAVE_PAUSE_BITS = 2;
  localparam int SLOT_TIME_NS     = 156000;
  localparam int BIT_TIME_NS      = SLOT_TIME_NS /
                                    (REQUEST_BITS + MASTER_PAUSE_BITS + RESPONSE_BITS + SLAVE_PAUSE_BITS);
  localparam int SHORT_CYCLE_NS   = 3000000;
  localparam int SHORT_CYCLE_MAX  = 19;
  localparam int CLOCK_NS         = 25;
  // Longest times round down
  localparam int SLOT_CYCLES      = SLOT_TIME_NS / CLOCK_NS;
  localparam int SHORT_CYCLE_CYCLES = SHORT_CYCLE_NS / CLOCK_NS;
endpackage : sbm_pkg
`default_nettype wire

/* verilog/sbm_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_master #(
  parameter sbm_pkg::sbm_profile_type PROFILE = sbm_pkg::full_profile,
  parameter int SLOT_CYCLES  = sbm_pkg::SLOT_CYCLES,
  parameter int SHORT_CYCLES = sbm_pkg::SHORT_CYCLE_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clock_enable,
  // Controller call port
  input  wire logic        call_valid,
  input  wire logic [4:0]  call_code,
  input  wire logic [4:0]  call_addr,
  input  wire logic [31:0] call_data,
  output logic             done,
  output logic [1:0]       status,
  output logic [31:0]      result,
  // Phase control
  input  wire logic        power_good,
  input  wire logic        config_mode,
  // Line side images, to and from the slave scanner
  input  wire logic [31:0] detected_slave_list,
  input  wire logic [3:0]  slave_input_data,
  input  wire logic [3:0]  slave_actual_param,
  input  wire logic [7:0]  slave_actual_cfg,
  output logic [4:0]       scan_addr,
  output logic [3:0]       slave_output_data,
  output logic [3:0]       slave_param_out,
  output logic             param_write,
  // Front panel
  output logic             panel_error_lamp,
  output logic             cfg_ok,
  output logic             cycle_tick
);
  typedef enum logic [1:0] {sbm_off, sbm_startup, sbm_running, sbm_shutdown} sbm_phase_type;

  sbm_phase_type phase;
  logic [31:0] input_data_image [32];
  logic [3:0]  output_data_image [32];
  logic [3:0]  stored_parameter_table [32];
  logic [3:0]  actual_parameter_image [32];
  logic [7:0]  stored_configuration_table [32];
  logic [7:0]  actual_configuration_table [32];
  logic [31:0] projected_slave_list;
  logic [31:0] activated_slave_list;
  logic [31:0] detected_sync;
  logic [31:0] detected_meta;
  logic [22:0] cycle_count;
  logic [22:0] cycle_limit;
  logic [5:0]  active_count;
  logic        supported;
  logic        cfg_mismatch;

  // Two-flop capture of the line side detection list
  always_ff @(posedge clock) begin
    if (rst) begin
      detected_meta <= 32'h0000_0000;
      detected_sync <= 32'h0000_0000;
    end else if (clock_enable) begin
      detected_meta <= detected_slave_list;
      detected_sync <= detected_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= sbm_off;
    end else if (clock_enable) begin
      case (phase)
        sbm_off:      phase <= power_good ? sbm_startup : sbm_off;
        sbm_startup:  phase <= power_good ? sbm_running : sbm_shutdown;
        sbm_running:  phase <= power_good ? sbm_running : sbm_shutdown;
        sbm_shutdown: phase <= sbm_off;
        default:      phase <= sbm_off;
      endcase
    end
  end

  always_comb begin
    supported = 1'b0;
    case (call_code)
      sbm_pkg::CALL_READ_INPUT, sbm_pkg::CALL_WRITE_OUTPUT,
      sbm_pkg::CALL_STORE_CFG, sbm_pkg::CALL_GET_CFG_OK,
      sbm_pkg::CALL_SET_OP_MODE: supported = 1'b1;
      sbm_pkg::CALL_WRITE_PARAM, sbm_pkg::CALL_STORE_PARAMS:
        supported = (PROFILE != sbm_pkg::minimum_profile);
      sbm_pkg::CALL_SET_PERM_PARAM, sbm_pkg::CALL_GET_PERM_PARAM,
      sbm_pkg::CALL_READ_PARAM, sbm_pkg::CALL_SET_PERM_CFG,
      sbm_pkg::CALL_GET_PERM_CFG, sbm_pkg::CALL_READ_ACT_CFG,
      sbm_pkg::CALL_SET_PROJECTED, sbm_pkg::CALL_GET_PROJECTED,
      sbm_pkg::CALL_GET_ACTIVATED, sbm_pkg::CALL_GET_DETECTED,
      sbm_pkg::CALL_GET_FLAGS:
        supported = (PROFILE == sbm_pkg::full_profile);
      default: supported = 1'b0;
    endcase
  end

  assign cfg_mismatch = (projected_slave_list != activated_slave_list);

  // Activated list follows detected slaves while running, projected ones only outside config mode
  always_ff @(posedge clock) begin
    if (rst) begin
      activated_slave_list <= 32'h0000_0000;
    end else if (clock_enable) begin
      if (phase != sbm_running) begin
        activated_slave_list <= 32'h0000_0000;
      end else if (config_mode) begin
        activated_slave_list <= detected_sync & 32'hFFFF_FFFE;
      end else begin
        activated_slave_list <= detected_sync & projected_slave_list & 32'hFFFF_FFFE;
      end
    end
  end

  // Per slave images; only slot of the scan address changes
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_slave
      always_ff @(posedge clock) begin
        if (rst) begin
          input_data_image[g]           <= 32'h0000_0000;
          actual_parameter_image[g]     <= sbm_pkg::PARAM_RESET;
          actual_configuration_table[g] <= sbm_pkg::CFG_RESET;
        end else if (clock_enable && scan_addr == 5'(g) && activated_slave_list[g]) begin
          input_data_image[g]           <= {28'h0000000, slave_input_data};
          actual_parameter_image[g]     <= slave_actual_param;
          actual_configuration_table[g] <= slave_actual_cfg;
        end
      end
    end
  endgenerate

  // Call execution; unsupported clears result and leaves tables and lists unchanged
  always_ff @(posedge clock) begin
    if (rst) begin
      done                 <= 1'b0;
      status               <= sbm_pkg::STATUS_OK;
      result               <= 32'h0000_0000;
      projected_slave_list <= 32'h0000_0000;
      param_write          <= 1'b0;
      slave_param_out      <= sbm_pkg::PARAM_RESET;
      for (int i = 0; i < 32; i++) begin
        output_data_image[i]          <= 4'h0;
        stored_parameter_table[i]     <= sbm_pkg::PARAM_RESET;
        stored_configuration_table[i] <= sbm_pkg::CFG_RESET;
      end
    end else if (clock_enable) begin
      done        <= call_valid;
      param_write <= 1'b0;
      if (call_valid) begin
        result <= 32'h0000_0000;
        if (!supported) begin
          status <= sbm_pkg::STATUS_UNSUPPORTED;
        end else begin
          status <= sbm_pkg::STATUS_OK;
          case (call_code)
            sbm_pkg::CALL_READ_INPUT:     result <= input_data_image[call_addr];
            sbm_pkg::CALL_WRITE_OUTPUT:   output_data_image[call_addr] <= call_data[3:0];
            sbm_pkg::CALL_SET_PERM_PARAM: stored_parameter_table[call_addr] <= call_data[3:0];
            sbm_pkg::CALL_GET_PERM_PARAM:
              result <= {28'h0000000, stored_parameter_table[call_addr]};
            sbm_pkg::CALL_WRITE_PARAM: begin
              slave_param_out <= call_data[3:0];
              param_write     <= 1'b1;
              result <= {28'h0000000, actual_parameter_image[call_addr]};
            end
            sbm_pkg::CALL_READ_PARAM:
              result <= {28'h0000000, actual_parameter_image[call_addr]};
            sbm_pkg::CALL_STORE_PARAMS:
              for (int i = 0; i < 32; i++) stored_parameter_table[i] <= actual_parameter_image[i];
            sbm_pkg::CALL_SET_PERM_CFG: stored_configuration_table[call_addr] <= call_data[7:0];
            sbm_pkg::CALL_GET_PERM_CFG:
              result <= {24'h000000, stored_configuration_table[call_addr]};
            sbm_pkg::CALL_STORE_CFG: begin
              for (int i = 0; i < 32; i++)
                stored_configuration_table[i] <= actual_configuration_table[i];
              projected_slave_list <= activated_slave_list;
            end
            sbm_pkg::CALL_READ_ACT_CFG:
              result <= {24'h000000, actual_configuration_table[call_addr]};
            sbm_pkg::CALL_SET_PROJECTED: projected_slave_list <= call_data & 32'hFFFF_FFFE;
            sbm_pkg::CALL_GET_PROJECTED: result <= projected_slave_list;
            sbm_pkg::CALL_GET_ACTIVATED: result <= activated_slave_list;
            sbm_pkg::CALL_GET_DETECTED:  result <= detected_sync;
            sbm_pkg::CALL_GET_FLAGS: begin
              result[sbm_pkg::FLAG_CFG_OK]     <= !cfg_mismatch;
              result[sbm_pkg::FLAG_CFG_ACTIVE] <= config_mode;
              result[sbm_pkg::FLAG_NORMAL_OP]  <= (phase == sbm_running);
              result[sbm_pkg::FLAG_OFFLINE]    <= (phase != sbm_running);
            end
            // same flag as the panel output, so both interfaces agree
            sbm_pkg::CALL_GET_CFG_OK: result <= {31'h0, cfg_ok};
            default: result <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // flag on panel too; lamp shows mismatch even in config mode
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ok           <= 1'b0;
      panel_error_lamp <= 1'b1;
    end else if (clock_enable) begin
      cfg_ok           <= !cfg_mismatch && phase == sbm_running;
      panel_error_lamp <= cfg_mismatch || phase != sbm_running;
    end
  end

  // slot per slave; count active slaves
  always_comb begin
    active_count = 6'h00;
    for (int i = 0; i < 32; i++) active_count = active_count + 6'(activated_slave_list[i]);
  end

  assign cycle_limit = (active_count <= 6'(sbm_pkg::SHORT_CYCLE_MAX))
                     ? 23'(SHORT_CYCLES)
                     : 23'((32'(active_count) + 32'h1) * 32'(SLOT_CYCLES));

  // Polling cycle timer, one scan slot per slave slot
  always_ff @(posedge clock) begin
    if (rst) begin
      cycle_count       <= 23'h000000;
      cycle_tick        <= 1'b0;
      scan_addr         <= 5'h00;
      slave_output_data <= 4'h0;
    end else if (clock_enable) begin
      cycle_tick <= 1'b0;
      if (phase != sbm_running) begin
        cycle_count       <= 23'h000000;
        scan_addr         <= 5'h00;
        slave_output_data <= 4'h0;
      end else if (cycle_count >= cycle_limit - 23'h1) begin
        cycle_count <= 23'h000000;
        cycle_tick  <= 1'b1;
        scan_addr   <= 5'h00;
      end else begin
        cycle_count <= cycle_count + 23'h1;
        if (cycle_count % 23'(SLOT_CYCLES) == 23'(SLOT_CYCLES - 1)) begin
          scan_addr         <= scan_addr + 5'h1;
          slave_output_data <= output_data_image[scan_addr + 5'h1];
        end
      end
    end
  end
endmodule : sbm_master
`default_nettype wire

/* sim/sbm_master_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_master_sva #(
  parameter sbm_pkg::sbm_profile_type PROFILE = sbm_pkg::full_profile,
  parameter int SLOT_CYCLES  = sbm_pkg::SLOT_CYCLES,
  parameter int SHORT_CYCLES = sbm_pkg::SHORT_CYCLE_CYCLES
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Call port
  input wire logic        clock_enable,
  input wire logic        call_valid,
  input wire logic [4:0]  call_code,
  input wire logic        done,
  input wire logic [1:0]  status,
  input wire logic [31:0] result,
  // Front panel
  input wire logic        panel_error_lamp,
  input wire logic        cfg_ok,
  input wire logic        cycle_tick
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  // Calls that each profile answers
  function automatic logic supp(input logic [4:0] c);
    if (PROFILE == sbm_pkg::full_profile) return c >= 5'h01 && c <= 5'h12;
    if (c == 5'h05 || c == 5'h07) return PROFILE == sbm_pkg::reduced_profile;
    return c inside {5'h01, 5'h02, 5'h0A, 5'h11, 5'h12};
  endfunction
  // A taken call
  assign take = call_valid && clock_enable;
  chk_done_next:
    assert property (take |=> done) else $error("done missing after call");
  chk_done_cause:
    assert property (clock_enable && !call_valid |=> !done) else $error("done without call");
  chk_refuse_code:
    assert property (take && !supp(call_code) |=> status == sbm_pkg::STATUS_UNSUPPORTED)
    else $error("call outside profile accepted");
  chk_profile_accept:
    assert property (take && supp(call_code) |=> status != sbm_pkg::STATUS_UNSUPPORTED)
    else $error("profile call refused");
  chk_status_hold:
    assert property (!done |-> $stable(status) && $stable(result))
    else $error("status moved without call");
  chk_lamp_flag:
    assert property (cfg_ok == !panel_error_lamp) else $error("lamp disagrees with flag");
  chk_cfg_result:
    assert property (take && call_code == sbm_pkg::CALL_GET_CFG_OK |=> result[0] == $past(cfg_ok))
    else $error("flag call disagrees with flag");
  chk_tick_pulse:
    assert property (cycle_tick |=> !cycle_tick [*3]) else $error("cycle tick too close");
endmodule : sbm_master_sva
bind sbm_master sbm_master_sva #(.PROFILE(PROFILE), .SLOT_CYCLES(SLOT_CYCLES),
  .SHORT_CYCLES(SHORT_CYCLES)) chk_u (.clock(clock), .rst(rst), .clock_enable(clock_enable),
  .call_valid(call_valid), .call_code(call_code), .done(done), .status(status),
  .result(result), .panel_error_lamp(panel_error_lamp), .cfg_ok(cfg_ok),
  .cycle_tick(cycle_tick));
`default_nettype wire

/* sim/sbm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_slave_model (
  // Slave being scanned
  input  wire logic [4:0] scan_addr,
  // Images the slave answers with
  output logic      [3:0] slave_input_data,
  output logic      [3:0] slave_actual_param,
  output logic      [7:0] slave_actual_cfg
);
  // Input and configuration values vary with address so a wrong slot shows
  always_comb begin
    slave_input_data   = ~scan_addr[3:0];
    slave_actual_param = 4'hF; // Unused bits answer high
    slave_actual_cfg   = {3'h0, scan_addr};
  end
endmodule : sbm_slave_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock, rst, clock_enable, call_valid, power_good, config_mode;
  logic [4:0]  call_code;
  logic [31:0] call_data, detected;
  logic        done_a[3], lamp_a[3], cfg_a[3], tick_a[3];
  logic [1:0]  status_a[3];
  logic [31:0] result_a[3];
  int          miscompares, samples_checked, n;
  // One instance per profile: minimum, full, reduced
  for (genvar g = 0; g < 3; g++) begin : prof
    logic [4:0] scan;
    logic [3:0] din, par;
    logic [7:0] cfg;
    sbm_master #(.PROFILE(sbm_pkg::sbm_profile_type'(g)), .SLOT_CYCLES(4), .SHORT_CYCLES(40))
      dut_u (.clock(clock), .rst(rst), .clock_enable(clock_enable), .call_valid(call_valid),
      .call_code(call_code), .call_addr(5'h01), .call_data(call_data), .done(done_a[g]),
      .status(status_a[g]), .result(result_a[g]), .power_good(power_good),
      .config_mode(config_mode), .detected_slave_list(detected), .slave_input_data(din),
      .slave_actual_param(par), .slave_actual_cfg(cfg), .scan_addr(scan),
      .slave_output_data(), .slave_param_out(), .param_write(), .panel_error_lamp(lamp_a[g]),
      .cfg_ok(cfg_a[g]), .cycle_tick(tick_a[g]));
    sbm_slave_model slave_u (.scan_addr(scan), .slave_input_data(din),
      .slave_actual_param(par), .slave_actual_cfg(cfg));
  end
  // 40 MHz
  always #12.5 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Call held over one taken edge; answer visible on return
  task automatic do_call(input logic [4:0] code, input logic [31:0] data);
    @(negedge clock);
    call_valid = 1'b1;
    call_code  = code;
    call_data  = data;
    @(negedge clock);
    call_valid = 1'b0;
  endtask : do_call
  task automatic wait_cfg(input logic v);
    for (int i = 0; i < 100 && cfg_a[1] !== v; i++) @(negedge clock);
  endtask : wait_cfg
  // Cycles between two ticks of the full master
  task automatic tick_gap(output int gap);
    int i;
    i = 0;
    while (tick_a[1] !== 1'b1 && i < 500) begin @(negedge clock); i++; end
    @(negedge clock);
    gap = 1;
    while (tick_a[1] !== 1'b1 && gap < 500) begin @(negedge clock); gap++; end
  endtask : tick_gap
  function automatic logic [1:0] exp_st(input int p, input int c);
    logic ok;
    ok = c inside {1, 2, 10, 17, 18} || (p == 1 && c <= 18) || (p == 2 && c inside {5, 7});
    return ok ? sbm_pkg::STATUS_OK : sbm_pkg::STATUS_UNSUPPORTED;
  endfunction : exp_st
  // Hang guard, well past the expected run
  initial begin
    #(25 * 20000);
    miscompares++;
    give_verdict();
  end
  initial begin
    {clock, call_valid, call_code, call_data, power_good, config_mode} = '0;
    {rst, clock_enable} = 2'b11;
    detected = 32'h0000_000E;
    repeat (10) @(negedge clock);
    for (int p = 0; p < 3; p++) check({lamp_a[p], cfg_a[p], done_a[p]}, 3'h4);
    rst = 1'b0;
    power_good = 1'b1;
    // Projected list matching, then naming an absent slave
    do_call(sbm_pkg::CALL_SET_PROJECTED, 32'h0000_000E);
    wait_cfg(1'b1);
    check({cfg_a[1], lamp_a[1]}, 2'h2);
    do_call(sbm_pkg::CALL_GET_CFG_OK, 32'h0);
    check(result_a[1][0], 1'b1);
    do_call(sbm_pkg::CALL_SET_PROJECTED, 32'h0000_001E);
    wait_cfg(1'b0);
    check({cfg_a[1], lamp_a[1]}, 2'h1);
    // Every code, out-of-range one included, on each profile
    for (int c = 1; c < 20; c++) begin
      do_call(c[4:0], 32'h0000_000E);
      for (int p = 0; p < 3; p++) begin
        check(done_a[p], 1'b1);
        check(status_a[p], exp_st(p, c));
      end
      if (c == 13) check(result_a[1], 32'h0000_000E);
      if (c == 16) check(result_a[1], 32'h0000_0005);
    end
    // Refused list calls left the minimum master's lists alone
    check(cfg_a[0], 1'b1);
    // Enable low: a call is not taken
    @(negedge clock);
    clock_enable = 1'b0;
    do_call(sbm_pkg::CALL_GET_PROJECTED, 32'h0);
    check(done_a[1], 1'b0);
    clock_enable = 1'b1;
    // Twenty activated slaves stretch the cycle
    // flag not read while configuring
    config_mode = 1'b1;
    detected = 32'h001F_FFFE;
    tick_gap(n);
    tick_gap(n);
    check(n, 32'd84);
    detected = 32'h0000_000E;
    tick_gap(n);
    tick_gap(n);
    check(n, 32'd40);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
